/* File: inc/stc_pkg.sv */
// constants and types shared by the scanner trigger cycle controller
package stc_pkg;
  // apb register byte offsets
  localparam logic [7:0] STC_CTRL_OFS  = 8'h00;
  localparam logic [7:0] STC_COUNT_OFS = 8'h04;
  localparam logic [7:0] STC_WIN_OFS   = 8'h08;
  localparam logic [7:0] STC_WDOG_OFS  = 8'h0C;
  localparam logic [7:0] STC_STAT_OFS  = 8'h10;
  localparam logic [7:0] STC_CMD_OFS   = 8'h14;
  localparam logic [7:0] STC_ISTAT_OFS = 8'h18;
  localparam logic [7:0] STC_IMASK_OFS = 8'h1C;
  // ctrl field positions
  localparam int STC_TYPE_LSB  = 0;
  localparam int STC_INV_BIT   = 2;
  localparam int STC_CLAS_BIT  = 3;
  localparam int STC_WDEN_BIT  = 4;
  localparam int STC_INT_LSB   = 5;
  localparam int STC_HWD_BIT   = 7;
  localparam int STC_SWD_LSB   = 8;
  // count / window field positions (each field 7 bits)
  localparam int STC_F0_LSB    = 0;
  localparam int STC_F1_LSB    = 8;
  localparam int STC_F2_LSB    = 16;
  // command bits
  localparam int STC_CMD_START = 0;
  localparam int STC_CMD_END   = 1;
  // reset values
  localparam logic [9:0] STC_CTRL_RST = 10'h003;
  localparam logic [6:0] STC_SBE_RST  = 7'h00;
  localparam logic [6:0] STC_WIN_RST  = 7'h03;
  localparam logic [6:0] STC_TTIM_RST = 7'h00;
  localparam logic [6:0] STC_ON_RST   = 7'h64;
  localparam logic [6:0] STC_DLY_RST  = 7'h00;
  localparam logic [7:0] STC_WDOG_RST = 8'h0A;
  // value limits
  localparam logic [6:0] STC_MAX_SET  = 7'h63;
  localparam logic [7:0] STC_MAX_PCT  = 8'h64;
  // timing: one timer step, and the clock period
  localparam int STC_STEP_US   = 10000;
  localparam int STC_CLK_NS    = 20;
  localparam int STC_STEP_CYC  = STC_STEP_US * 1000 / STC_CLK_NS;
  // trigger types
  typedef enum logic [1:0] {
    STC_TRIG_SERIAL = 2'h0,
    STC_TRIG_CONT_T = 2'h1,
    STC_TRIG_CONT_X = 2'h2,
    STC_TRIG_HW     = 2'h3
  } stc_trig_t;
  // laser intensity modes
  typedef enum logic [1:0] {
    STC_INT_LOW  = 2'h0,
    STC_INT_HIGH = 2'h1,
    STC_INT_AUTO = 2'h2,
    STC_INT_ALT  = 2'h3
  } stc_int_t;
  // cycle state, one-hot
  typedef enum logic [3:0] {
    STC_IDLE   = 4'h1,
    STC_ACTIVE = 4'h2,
    STC_DRAIN  = 4'h4,
    STC_HOLD   = 4'h8
  } stc_state_t;
  // interrupt status bits
  localparam int STC_EV_TX = 0;
  localparam int STC_EV_NR = 1;
  localparam int STC_EV_HW = 2;
  localparam int STC_EV_WD = 3;
endpackage

/* File: verilog/stc_sync.sv */
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module stc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire logic         i_clk_en,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_reg <= '0;
      o_sync   <= '0;
    end
    else if (i_clk_en)
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule // stc_sync

/* File: verilog/stc_top.sv */
// scanner trigger cycle controller with apb registers
`timescale 1ns/1ps
module stc_top
  import stc_pkg::*;
#(
  parameter int TICK_CYCLES = STC_STEP_CYC
) (
  // clock, reset, enable
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_clk_en,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // pins: trigger sensor and failure detectors
  input  wire logic        i_trig_pin,
  input  wire logic [2:0]  i_fault_pin,
  // scan engine, same clock
  input  wire logic        i_scan_done,
  input  wire logic        i_decode_valid,
  input  wire logic [6:0]  i_scan_pos,
  input  wire logic        i_proc_done,
  input  wire logic        i_auto_intensity_select,
  // outputs
  output logic             o_laser_on,
  output logic             o_laser_high,
  output logic             o_scan_gate,
  output logic             o_transmit,
  output logic             o_no_read,
  output logic             o_diag_msg,
  output logic [2:0]       o_diag_code,
  output logic [1:0]       o_sw_diag_mode,
  output logic             o_irq
);
  typedef struct packed {
    stc_state_t  state;
    logic [9:0]  ctrl;
    logic [6:0]  sbe;
    logic [6:0]  win;
    logic [6:0]  ttim;
    logic [6:0]  on_pct;
    logic [6:0]  dly_pct;
    logic [7:0]  wdog;
    logic        serial_on;
    logic        trig_prev;
    logic [6:0]  scan_cnt;
    logic [6:0]  dec_cnt;
    logic [31:0] pre;
    logic [6:0]  tick_cnt;
    logic [7:0]  wd_cnt;
    logic [3:0]  istat;
    logic [3:0]  imask;
    logic [2:0]  fault_prev;
    logic        laser;
    logic        high;
    logic        alt;
    logic        xmit;
    logic        noread;
    logic        diag;
    logic [2:0]  diag_code;
    logic        gate;
    logic        irq;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } stc_regs_t;

  stc_regs_t  r_reg;
  stc_regs_t  r_next;
  logic       trig_s;
  logic [2:0] fault_s;

  // pins cross into the clock domain first
  stc_sync #(.W(4)) u_sync (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_clk_en (i_clk_en),
    .i_async  ({i_fault_pin, i_trig_pin}),
    .o_sync   ({fault_s, trig_s})
  );

  // threshold of 00 behaves as 1
  function automatic logic win_met(input logic [6:0] cnt, input logic [6:0] thr);
    win_met = (cnt >= ((thr == 7'h00) ? 7'h01 : thr));
  endfunction

  // scan and decode counters saturate at 99 so they can be compared to settings
  function automatic logic [6:0] sat_inc(input logic [6:0] v);
    sat_inc = (v >= STC_MAX_SET) ? STC_MAX_SET : v + 7'h01;
  endfunction

  // scan, threshold and timer settings above 99 are clamped
  function automatic logic [6:0] clamp99(input logic [6:0] v);
    clamp99 = (v > STC_MAX_SET) ? STC_MAX_SET : v;
  endfunction

  stc_trig_t  ttype;
  logic       trig_en;
  logic       cont;
  logic       tick;
  logic       acc;
  logic       fin;
  logic [7:0] sum;
  logic [6:0] dec_n;
  logic [6:0] scan_n;
  logic [3:0] ev;
  logic [2:0] frise;
  logic       cyc_end;
  logic       wd_exp;

  // whole next-state computation
  always_comb
  begin
    r_next  = r_reg;
    ttype   = stc_trig_t'(r_reg.ctrl[STC_TYPE_LSB +: 2]);
    cont    = (ttype == STC_TRIG_CONT_T) || (ttype == STC_TRIG_CONT_X);
    // pin polarity picks the enabled level
    trig_en = (ttype == STC_TRIG_SERIAL) ? r_reg.serial_on
                                         : (trig_s ^ r_reg.ctrl[STC_INV_BIT]);
    tick    = (r_reg.pre == 32'(TICK_CYCLES - 1));
    acc     = i_psel && i_penable && !r_reg.pready;
    fin     = i_psel && i_penable && r_reg.pready;
    sum     = {1'b0, i_pwdata[STC_F0_LSB +: 7]} + {1'b0, i_pwdata[STC_F1_LSB +: 7]};
    dec_n   = i_decode_valid ? sat_inc(r_reg.dec_cnt) : r_reg.dec_cnt;
    scan_n  = i_scan_done ? sat_inc(r_reg.scan_cnt) : r_reg.scan_cnt;
    ev      = 4'h0;
    frise   = fault_s & ~r_reg.fault_prev;
    cyc_end = 1'b0;
    wd_exp  = 1'b0;
    r_next.xmit      = 1'b0;
    r_next.noread    = 1'b0;
    r_next.diag      = 1'b0;
    r_next.trig_prev = trig_en;
    r_next.fault_prev = fault_s;
    r_next.pre       = tick ? 32'h0000_0000 : r_reg.pre + 32'h0000_0001;
    r_next.scan_cnt  = scan_n;
    r_next.dec_cnt   = dec_n;

    // trigger cycle sequencing
    unique case (r_reg.state)
      STC_IDLE:
      begin
        if (cont)
        begin
          // no scan limit here, only the decode threshold
          if (win_met(dec_n, r_reg.win))
          begin
            r_next.xmit    = 1'b1;
            r_next.dec_cnt = 7'h00;
          end
        end
        else if (trig_en && !r_reg.trig_prev)
        begin
          r_next.state    = STC_ACTIVE;
          r_next.scan_cnt = 7'h00;
          r_next.dec_cnt  = 7'h00;
          r_next.tick_cnt = 7'h00;
          r_next.pre      = 32'h0000_0000;
        end
      end
      STC_ACTIVE:
      begin
        if (tick)
          r_next.tick_cnt = r_reg.tick_cnt + 7'h01;
        // timer of 00 never expires; expiry counts 10 ms steps
        cyc_end = !trig_en || ((r_reg.ttim != 7'h00) && (r_reg.tick_cnt >= r_reg.ttim));
        if (cont)
          r_next.state = STC_IDLE;
        else if ((r_reg.sbe != 7'h00) && (scan_n >= r_reg.sbe) && win_met(dec_n, r_reg.win))
        begin
          // early exit only once both scan count and threshold hold
          r_next.xmit  = 1'b1;
          r_next.state = STC_HOLD;
        end
        else if (cyc_end)
        begin
          r_next.state  = STC_DRAIN;
          r_next.wd_cnt = 8'h00;
          r_next.pre    = 32'h0000_0000;
        end
      end
      STC_DRAIN:
      begin
        if (tick)
          r_next.wd_cnt = r_reg.wd_cnt + 8'h01;
        // watchdog forces the verdict so the host is never left waiting
        wd_exp = r_reg.ctrl[STC_WDEN_BIT] && (r_reg.wd_cnt >= r_reg.wdog);
        if (i_proc_done || wd_exp)
        begin
          if (win_met(dec_n, r_reg.win))
            r_next.xmit = 1'b1;
          else
            r_next.noread = 1'b1;
          ev[STC_EV_WD] = wd_exp && !i_proc_done;
          r_next.state  = STC_HOLD;
        end
      end
      STC_HOLD:
      begin
        // a new cycle needs a fresh trigger edge
        if (!trig_en)
          r_next.state = STC_IDLE;
      end
    endcase

    // laser gating and intensity
    r_next.laser = r_reg.ctrl[STC_CLAS_BIT] || trig_en;
    if (i_scan_done)
      r_next.alt = !r_reg.alt;
    unique case (stc_int_t'(r_reg.ctrl[STC_INT_LSB +: 2]))
      STC_INT_LOW:  r_next.high = 1'b0;
      STC_INT_HIGH: r_next.high = 1'b1;
      STC_INT_AUTO: r_next.high = i_auto_intensity_select;
      STC_INT_ALT:  r_next.high = r_reg.alt;
    endcase

    // window on sweep position, both in percent
    r_next.gate = (i_scan_pos >= r_reg.dly_pct) &&
                  ({1'b0, i_scan_pos} < ({1'b0, r_reg.dly_pct} + {1'b0, r_reg.on_pct}));

    // new failures in the same cycle share one message, their bits together in the code
    if (r_reg.ctrl[STC_HWD_BIT] && (frise != 3'h0))
    begin
      r_next.diag      = 1'b1;
      r_next.diag_code = frise;
      ev[STC_EV_HW]    = 1'b1;
    end
    ev[STC_EV_TX] = r_next.xmit;
    ev[STC_EV_NR] = r_next.noread;

    // apb: first access cycle prepares the answer, second completes it
    // error flag lives only as long as pready so the output needs no gate
    r_next.pready  = acc;
    r_next.pslverr = 1'b0;
    if (acc)
    begin
      r_next.pslverr = 1'b0;
      r_next.prdata  = 32'h0000_0000;
      unique case (i_paddr)
        STC_CTRL_OFS:  r_next.prdata = {22'h0, r_reg.ctrl};
        STC_COUNT_OFS: r_next.prdata = {9'h0, r_reg.ttim, 1'b0, r_reg.win, 1'b0, r_reg.sbe};
        STC_WIN_OFS:
        begin
          r_next.prdata  = {17'h0, r_reg.dly_pct, 1'b0, r_reg.on_pct};
          r_next.pslverr = i_pwrite && (sum > STC_MAX_PCT);
        end
        STC_WDOG_OFS:  r_next.prdata = {24'h0, r_reg.wdog};
        STC_STAT_OFS:  r_next.prdata = {9'h0, r_reg.dec_cnt, 1'b0, r_reg.scan_cnt,
                                        2'h0, trig_en, r_reg.laser, r_reg.state};
        STC_CMD_OFS:   r_next.prdata = {31'h0, r_reg.serial_on};
        STC_ISTAT_OFS: r_next.prdata = {28'h0, r_reg.istat};
        STC_IMASK_OFS: r_next.prdata = {28'h0, r_reg.imask};
        default:       r_next.pslverr = 1'b1;
      endcase
    end
    if (fin && i_pwrite && !r_reg.pslverr)
    begin
      unique case (i_paddr)
        STC_CTRL_OFS:  r_next.ctrl = i_pwdata[9:0];
        STC_COUNT_OFS:
        begin
          r_next.sbe  = clamp99(i_pwdata[STC_F0_LSB +: 7]);
          r_next.win  = clamp99(i_pwdata[STC_F1_LSB +: 7]);
          r_next.ttim = clamp99(i_pwdata[STC_F2_LSB +: 7]);
        end
        STC_WIN_OFS:
        begin
          r_next.on_pct  = i_pwdata[STC_F0_LSB +: 7];
          r_next.dly_pct = i_pwdata[STC_F1_LSB +: 7];
        end
        STC_WDOG_OFS:  r_next.wdog = i_pwdata[7:0];
        STC_CMD_OFS:
        begin
          if (i_pwdata[STC_CMD_START])
            r_next.serial_on = 1'b1;
          else if (i_pwdata[STC_CMD_END])
            r_next.serial_on = 1'b0;
        end
        STC_IMASK_OFS: r_next.imask = i_pwdata[3:0];
        default:       r_next.ctrl = r_reg.ctrl;
      endcase
    end

    // write one clears; a new event in the same cycle wins
    if (fin && i_pwrite && (i_paddr == STC_ISTAT_OFS))
      r_next.istat = r_reg.istat & ~i_pwdata[3:0];
    r_next.istat = r_next.istat | ev;
    r_next.irq   = (r_next.istat & r_next.imask) != 4'h0;
  end

  // single state register; reset clears diag mode so it never persists
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      r_reg          <= '0;
      r_reg.state    <= STC_IDLE;
      r_reg.ctrl     <= STC_CTRL_RST;
      r_reg.sbe      <= STC_SBE_RST;
      r_reg.win      <= STC_WIN_RST;
      r_reg.ttim     <= STC_TTIM_RST;
      r_reg.on_pct   <= STC_ON_RST;
      r_reg.dly_pct  <= STC_DLY_RST;
      r_reg.wdog     <= STC_WDOG_RST;
    end
    else if (i_clk_en)
      r_reg <= r_next;
  end

  // outputs straight from the state register
  assign o_pready       = r_reg.pready;
  assign o_prdata       = r_reg.prdata;
  assign o_pslverr      = r_reg.pslverr;
  assign o_laser_on     = r_reg.laser;
  assign o_laser_high   = r_reg.high;
  assign o_scan_gate    = r_reg.gate;
  assign o_transmit     = r_reg.xmit;
  assign o_no_read      = r_reg.noread;
  assign o_diag_msg     = r_reg.diag;
  assign o_diag_code    = r_reg.diag_code;
  assign o_sw_diag_mode = r_reg.ctrl[STC_SWD_LSB +: 2];
  assign o_irq          = r_reg.irq;

  // checks
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  tx_threshold_a: assert property (i_clk_en && r_next.xmit |=> win_met(r_reg.dec_cnt, r_reg.win) || $past(i_decode_valid)) else $error("transmit below threshold");
  early_exit_a: assert property (i_clk_en && r_reg.state == STC_ACTIVE && !cont && r_reg.sbe == 7'h00 |=> r_reg.state != STC_HOLD) else $error("early exit with scans 00");
  cont_state_a: assert property (cont && r_reg.state == STC_ACTIVE && i_clk_en |=> r_reg.state == STC_IDLE) else $error("continuous type held a cycle");
  timer_end_a: assert property (i_clk_en && r_reg.state == STC_ACTIVE && !cont && r_reg.ttim == 7'h00 && trig_en && !r_next.xmit |=> r_reg.state == STC_ACTIVE) else $error("disabled timer ended cycle");
  laser_cont_a: assert property (i_clk_en && r_reg.ctrl[STC_CLAS_BIT] |=> o_laser_on) else $error("laser off in continuous mode");
  laser_trig_a: assert property (i_clk_en && !r_reg.ctrl[STC_CLAS_BIT] && !trig_en |=> !o_laser_on) else $error("laser lit without trigger");
  wd_bound_a: assert property (i_clk_en && r_reg.state == STC_DRAIN && wd_exp |=> r_reg.state == STC_HOLD && (o_transmit || o_no_read)) else $error("watchdog missed");
  noread_a: assert property (o_no_read |-> !o_transmit && r_reg.state == STC_HOLD) else $error("no-read with transmit");
  win_sum_a: assert property ({1'b0, r_reg.dly_pct} + {1'b0, r_reg.on_pct} <= STC_MAX_PCT || $past(r_reg.dly_pct) == r_reg.dly_pct && $past(r_reg.on_pct) == r_reg.on_pct) else $error("window sum over 100");
  gate_a: assert property (i_clk_en && i_scan_pos < r_reg.dly_pct |=> !o_scan_gate) else $error("gate before delay");
  diag_a: assert property (o_diag_msg |-> $past(r_reg.ctrl[STC_HWD_BIT])) else $error("diag message while disabled");
  pready_a: assert property (o_pready |=> !o_pready) else $error("pready longer than one cycle");

  tx_cov_c: cover property (r_reg.state == STC_DRAIN ##1 o_transmit);
  nr_cov_c: cover property (o_no_read);
  early_cov_c: cover property (r_reg.state == STC_ACTIVE ##1 r_reg.state == STC_HOLD);
  wd_cov_c: cover property (wd_exp && !i_proc_done);
endmodule // stc_top

/* File: dv/stc_far_model.sv */
// far side model: presence sensor and serial host listener
`timescale 1ns/1ps
module stc_far_model (
  // clock
  input  wire logic       i_clock,
  // sensor request from the bench
  input  wire logic       i_want,
  input  wire logic       i_inv,
  // messages from the device
  input  wire logic       i_transmit,
  input  wire logic       i_no_read,
  input  wire logic       i_diag_msg,
  input  wire logic [2:0] i_diag_code,
  // sensor pin
  output logic            o_trig_pin
);
  int         n_tx = 0;
  int         n_nr = 0;
  int         n_dg = 0;
  logic [2:0] code = 3'h0;
  initial o_trig_pin = 1'b0;
  // pin is low-active when the sensor is wired inverted
  always @(posedge i_clock) o_trig_pin <= i_want ^ i_inv;
  // host counts each message; pulses last one cycle, so one look per edge
  always @(posedge i_clock)
  begin
    if (i_transmit === 1'b1) n_tx <= n_tx + 1;
    if (i_no_read === 1'b1) n_nr <= n_nr + 1;
    if (i_diag_msg === 1'b1) n_dg <= n_dg + 1;
    if (i_diag_msg === 1'b1) code <= i_diag_code;
  end
endmodule // stc_far_model

/* File: dv/test_scanner_trigger_cycle_control.sv */
// self-checking bench for the scanner trigger cycle controller
`timescale 1ns/1ps
module test_scanner_trigger_cycle_control;
  import stc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic        scan = 1'b0;
  logic        dec = 1'b0;
  logic [6:0]  pos = 7'h00;
  logic        pdone = 1'b1;
  logic        auto = 1'b0;
  logic        want = 1'b0;
  logic        inv = 1'b0;
  logic [2:0]  fault = 3'h0;
  logic        pready, pslverr, trig, l_on, l_hi, gate, tx, nr, dmsg, irq;
  logic [31:0] prd, rd;
  logic [2:0]  dcode;
  logic [1:0]  swd;
  logic        er;
  logic [7:0]  lfsr = 8'h26;
  int          err_total = 0;
  int          tests_run = 0;
  int          exp_tx = 0;
  int          exp_nr = 0;
  int          exp_dg = 0;
  int          p;
  // 50 MHz clock
  always #10 clk = ~clk;
  // short timer step keeps the run brief
  stc_top #(.TICK_CYCLES(4)) dut (
    .i_clock(clk), .i_rst(rst), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
    .i_pwdata(pwd), .o_pready(pready), .o_prdata(prd), .o_pslverr(pslverr),
    .i_trig_pin(trig), .i_fault_pin(fault), .i_scan_done(scan),
    .i_decode_valid(dec), .i_scan_pos(pos), .i_proc_done(pdone),
    .i_auto_intensity_select(auto), .o_laser_on(l_on), .o_laser_high(l_hi),
    .o_scan_gate(gate), .o_transmit(tx), .o_no_read(nr), .o_diag_msg(dmsg),
    .o_diag_code(dcode), .o_sw_diag_mode(swd), .o_irq(irq));
  // sensor and host on the far side
  stc_far_model far (
    .i_clock(clk), .i_want(want), .i_inv(inv), .i_transmit(tx),
    .i_no_read(nr), .i_diag_msg(dmsg), .i_diag_code(dcode), .o_trig_pin(trig));
  // next pseudo-random value
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    rd = prd;
    er = pslverr;
    chk("apb ready", n < 40, 32'h1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
    if (n >= 40) stop_test;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask
  task automatic trg(input logic v, input int n);
    want <= v;
    cyc(n);
  endtask
  task automatic pulses(input int ns, input int nd);
    for (int k = 0; k < ns || k < nd; k++)
    begin
      scan <= (k < ns);
      dec <= (k < nd);
      @(posedge clk);
    end
    scan <= 1'b0;
    dec <= 1'b0;
    @(posedge clk);
  endtask
  // host-side message counts against the bench's own tally
  task automatic wait_ev;
    int n;
    n = 0;
    while ((far.n_tx != exp_tx || far.n_nr != exp_nr || far.n_dg != exp_dg) && n < 80)
    begin
      @(posedge clk);
      n++;
    end
    chk("transmits", far.n_tx, exp_tx);
    chk("no-reads", far.n_nr, exp_nr);
    chk("diag msgs", far.n_dg, exp_dg);
    if (n >= 80) stop_test;
  endtask
  // main sequence
  initial
  begin
    cyc(6);
    rst <= 1'b0;
    cyc(1);
    rchk("ctrl rst", STC_CTRL_OFS, 32'h3FF, 32'h003);
    rchk("count rst", STC_COUNT_OFS, 32'h7F7F7F, 32'h300);
    rchk("win rst", STC_WIN_OFS, 32'h7F7F, 32'h64);
    rchk("wdog rst", STC_WDOG_OFS, 32'hFF, 32'h0A);
    apb(1'b1, 8'h20, 32'h0);
    chk("unmapped", er, 32'h1);
    apb(1'b1, STC_WIN_OFS, 32'h3C32);
    chk("win sum", er, 32'h1);
    rchk("win kept", STC_WIN_OFS, 32'h7F7F, 32'h64);
    apb(1'b1, STC_COUNT_OFS, 32'h7F);
    rchk("sbe clamp", STC_COUNT_OFS, 32'h7F, 32'h63);
    apb(1'b1, STC_IMASK_OFS, 32'h1);
    // hardware cycle, no decodes: laser follows trigger, ends in no-read
    trg(1'b1, 6);
    chk("laser up", l_on, 32'h1);
    trg(1'b0, 6);
    chk("laser down", l_on, 32'h0);
    exp_nr++;
    wait_ev;
    chk("irq masked", irq, 32'h0);
    rchk("istat", STC_ISTAT_OFS, 32'h3, 32'h2);
    apb(1'b1, STC_ISTAT_OFS, 32'h2);
    rchk("istat clr", STC_ISTAT_OFS, 32'h3, 32'h0);
    // continuous transmit type, inverted sensor switched in while ignored
    apb(1'b1, STC_CTRL_OFS, 32'h002);
    apb(1'b1, STC_COUNT_OFS, 32'h0201);
    inv <= 1'b1;
    apb(1'b1, STC_CTRL_OFS, 32'h006);
    cyc(4);
    chk("inv idle", l_on, 32'h0);
    trg(1'b1, 6);
    chk("inv on", l_on, 32'h1);
    trg(1'b0, 6);
    pulses(0, 1);
    cyc(5);
    wait_ev;
    pulses(0, 1);
    exp_tx++;
    wait_ev;
    cyc(2);
    chk("irq set", irq, 32'h1);
    apb(1'b1, STC_ISTAT_OFS, 32'h1);
    cyc(2);
    chk("irq clr", irq, 32'h0);
    inv <= 1'b0;
    apb(1'b1, STC_CTRL_OFS, 32'h00A);
    cyc(6);
    chk("cont laser", l_on, 32'h1);
    // hardware trigger with scans-before-exit 2, minimum decodes 2
    apb(1'b1, STC_CTRL_OFS, 32'h003);
    apb(1'b1, STC_COUNT_OFS, 32'h0202);
    trg(1'b1, 6);
    pulses(1, 1);
    cyc(4);
    wait_ev;
    pulses(1, 1);
    exp_tx++;
    wait_ev;
    trg(1'b0, 6);
    // timer off: cycle lasts until trigger end, then transmits
    apb(1'b1, STC_WDOG_OFS, 32'h01);
    apb(1'b1, STC_COUNT_OFS, 32'h000100);
    trg(1'b1, 4);
    cyc(30);
    rchk("no timer", STC_STAT_OFS, 32'hF, 32'h2);
    pulses(0, 1);
    trg(1'b0, 4);
    exp_tx++;
    wait_ev;
    // timer 3 steps ends the cycle; watchdog off leaves drain open
    pdone <= 1'b0;
    apb(1'b1, STC_COUNT_OFS, 32'h030100);
    trg(1'b1, 4);
    rchk("timer run", STC_STAT_OFS, 32'hF, 32'h2);
    cyc(20);
    rchk("timer end", STC_STAT_OFS, 32'hF, 32'h4);
    pdone <= 1'b1;
    exp_nr++;
    wait_ev;
    trg(1'b0, 6);
    // watchdog of one step forces the answer without processing done
    apb(1'b1, STC_CTRL_OFS, 32'h013);
    apb(1'b1, STC_COUNT_OFS, 32'h000100);
    pdone <= 1'b0;
    trg(1'b1, 6);
    pulses(0, 1);
    trg(1'b0, 2);
    exp_tx++;
    wait_ev;
    pdone <= 1'b1;
    // serial trigger by command, too few decodes
    apb(1'b1, STC_CTRL_OFS, 32'h000);
    apb(1'b1, STC_COUNT_OFS, 32'h000300);
    apb(1'b1, STC_CMD_OFS, 32'h1);
    pulses(1, 1);
    apb(1'b1, STC_CMD_OFS, 32'h2);
    exp_nr++;
    wait_ev;
    // every intensity mode; auto follows a random select input
    for (int m = 0; m < 4; m++)
    begin
      lfsr = nxt(lfsr);
      auto <= lfsr[0];
      apb(1'b1, STC_CTRL_OFS, 32'h003 | (m << 5));
      cyc(3);
      if (m < 3) chk("intensity", l_hi, (m == 1) || (m == 2 && auto));
      else
      begin
        p = l_hi;
        pulses(1, 0);
        cyc(2);
        chk("alternate", l_hi, !p[0]);
      end
    end
    // scan window delay 10, on 20: edges then random positions
    apb(1'b1, STC_WIN_OFS, 32'h0A14);
    for (int k = 0; k < 14; k++)
    begin
      lfsr = nxt(lfsr);
      p = (k == 0) ? 9 : (k == 1) ? 10 : (k == 2) ? 29 : (k == 3) ? 30 : lfsr % 100;
      pos <= p[6:0];
      cyc(3);
      chk("gate", gate, (p >= 10 && p < 30));
    end
    // laser diode failure with hardware diagnostics on
    apb(1'b1, STC_CTRL_OFS, 32'h083);
    fault <= 3'h2;
    exp_dg++;
    wait_ev;
    chk("diag code", far.code, 32'h2);
    fault <= 3'h0;
    // software diagnostic modes, lost again at reset
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, STC_CTRL_OFS, 32'h003 | (m << 8));
      cyc(2);
      chk("sw diag", swd, m);
    end
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    chk("sw diag rst", swd, 32'h0);
    rchk("ctrl again", STC_CTRL_OFS, 32'h3FF, 32'h003);
    stop_test;
  end
endmodule // test_scanner_trigger_cycle_control
